// File: verilog/tps_timer.sv
`default_nettype none

module tps_timer
  import tps_pkg::*;
#(
  parameter int PS_W = TPS_PS_WIDTH,
  parameter int CNT_W = TPS_CNT_WIDTH
) (
  // Oscillator clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // External count clock pin
  input wire logic i_ext_count_clock_in,
  // Watchdog side
  input wire logic i_dog_tick,
  input wire logic i_dog_clear_instr,
  output logic o_dog_timeout,
  // Register port
  input wire logic [TPS_ADDR_WIDTH-1:0] i_addr,
  input wire logic [TPS_DATA_WIDTH-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [TPS_DATA_WIDTH-1:0] o_rdata,
  // Status
  output logic [TPS_NUM_PHASES-1:0] o_phase,
  output logic [CNT_W-1:0] o_count_register
);

  // Low bits of the scaler that must be all ones for a dog postscale
  function automatic logic [PS_W-1:0] ratio_mask(input tps_ratio_t r);
    logic [PS_W-1:0] m;
    m = '0;
    for (int i = 0; i < PS_W; i++) begin
      if (i < int'(r)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  logic [1:0] phase_cnt_r;
  logic [TPS_OPT_W-1:0] option_r;
  logic [PS_W-1:0] ps_r;
  logic sync2_w;
  logic sync_d_r;
  logic pin_rise;
  logic scaler_assign_sel;
  tps_ratio_t scale_ratio_sel;
  logic ps_out;
  logic samp_r;
  logic inc_r;
  logic sample_now;
  logic wr_count;
  logic wr_option;
  logic ps_clear;

  assign scaler_assign_sel = option_r[TPS_OPT_ASSIGN_BIT];
  assign scale_ratio_sel =
    option_r[TPS_OPT_RATIO_LSB +: TPS_OPT_RATIO_W];
  assign wr_count = i_wr && (i_addr == TPS_ADDR_COUNT);
  assign wr_option = i_wr && (i_addr == TPS_ADDR_OPTION);

  // Phase generator
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      phase_cnt_r <= TPS_PHASE_RST;
    end else begin
      phase_cnt_r <= phase_cnt_r + 2'h1; // [R01]
    end
  end

  // One-hot view of the phase now in force
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_phase <= 4'h1;
    end else begin
      o_phase <= {o_phase[2:0], o_phase[3]}; // [R01]
    end
  end

  // Count clock pin crosses in through two flops
  tps_sync2 #(
    .W(1)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_async(i_ext_count_clock_in),
    .o_sync(sync2_w)
  );

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync_d_r <= 1'b0;
    end else begin
      sync_d_r <= sync2_w;
    end
  end

  assign pin_rise = sync2_w && !sync_d_r;

  // Option register, rewritable at any time
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      option_r <= TPS_OPTION_RST;
    end else if (wr_option) begin
      option_r <= i_wdata[TPS_OPT_W-1:0]; // [R09] [R14]
    end
  end

  // Scaler clear sources depend on the current owner
  assign ps_clear =
    (!scaler_assign_sel && wr_count) || // [R10]
    (scaler_assign_sel && i_dog_clear_instr); // [R11]

  // Shared scaler. Not on the register map, so software
  // can neither see nor load it.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ps_r <= TPS_PS_RST; // [R13]
    end else if (ps_clear) begin
      ps_r <= TPS_PS_RST;
    end else if (!scaler_assign_sel && pin_rise) begin
      ps_r <= ps_r + 1'b1; // [R05] [R08]
    end else if (scaler_assign_sel && i_dog_tick) begin
      ps_r <= ps_r + 1'b1; // [R08]
    end
  end

  // Timer divides by two to the power ratio plus one;
  // a counter bit toggles evenly so the output is symmetric.
  always_comb begin
    if (scaler_assign_sel) begin
      ps_out = sync2_w; // [R02]
    end else begin
      ps_out = ps_r[scale_ratio_sel]; // [R05] [R17]
    end
  end

  assign sample_now = (phase_cnt_r == TPS_PH_TWO) ||
                      (phase_cnt_r == TPS_PH_FOUR);

  // Sampling on two phases per cycle is what limits pulse width
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      samp_r <= 1'b0;
      inc_r <= 1'b0;
    end else if (sample_now) begin
      samp_r <= ps_out; // [R03]
      inc_r <= ps_out && !samp_r; // [R03] [R07]
    end else begin
      inc_r <= 1'b0;
    end
  end

  // Timer count; a software write beats a pending step
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_count_register <= TPS_COUNT_RST;
    end else if (wr_count) begin
      o_count_register <= i_wdata[CNT_W-1:0];
    end else if (inc_r) begin
      o_count_register <= o_count_register + 1'b1; // [R18]
    end
  end

  // Dog timeout is unscaled while the timer owns the scaler
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dog_timeout <= 1'b0;
    end else if (!scaler_assign_sel) begin
      o_dog_timeout <= i_dog_tick; // [R08]
    end else begin
      o_dog_timeout <= i_dog_tick && !i_dog_clear_instr &&
        ((ps_r & ratio_mask(scale_ratio_sel)) ==
         ratio_mask(scale_ratio_sel)); // [R17]
    end
  end

  // Read port, one cycle latency; unmapped reads give zero
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= '0;
    end else if (i_rd && i_addr == TPS_ADDR_COUNT) begin
      o_rdata <= o_count_register;
    end else if (i_rd && i_addr == TPS_ADDR_OPTION) begin
      o_rdata <= {{(TPS_DATA_WIDTH-TPS_OPT_W){1'b0}}, option_r};
    end else begin
      o_rdata <= '0; // [R12]
    end
  end

  // Assertion helpers: latency from synced pin rise to a step
  localparam int LAT_MIN = TPS_INC_DLY_MIN_CYC;
  localparam int LAT_MAX = TPS_INC_DLY_MAX_CYC;
  logic [3:0] lat_r;
  logic lat_armed_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lat_r <= 4'h0;
      lat_armed_r <= 1'b0;
    end else if (pin_rise && scaler_assign_sel) begin
      lat_r <= 4'h0;
      lat_armed_r <= 1'b1;
    end else if (inc_r) begin
      lat_armed_r <= 1'b0;
    end else if (lat_r != 4'hF) begin
      lat_r <= lat_r + 4'h1;
    end
  end

  sequence s_pin_rise_bypass;
    pin_rise && scaler_assign_sel && !samp_r && !wr_option;
  endsequence

  sequence s_step_soon;
    ##[1:3] inc_r;
  endsequence

  a_phase_onehot: assert property (@(posedge i_clk) disable iff (i_srst)
    $onehot(o_phase)) // [R01]
    else $error("phase not one-hot");

  a_phase_order: assert property (@(posedge i_clk) disable iff (i_srst)
    (phase_cnt_r == TPS_PH_FOUR) |=> (phase_cnt_r == TPS_PH_ONE) ##1
    (phase_cnt_r == TPS_PH_TWO) ##1 (phase_cnt_r == TPS_PH_THREE)) // [R01]
    else $error("phase sequence broken");

  a_bypass_path: assert property (@(posedge i_clk) disable iff (i_srst)
    scaler_assign_sel |-> (ps_out == sync2_w)) // [R02]
    else $error("unscaled path not direct");

  a_sample_phase: assert property (@(posedge i_clk) disable iff (i_srst)
    !$stable(samp_r) |-> ($past(phase_cnt_r) == TPS_PH_TWO ||
    $past(phase_cnt_r) == TPS_PH_FOUR)) // [R03]
    else $error("sample outside phases two and four");

  a_ratio_pick: assert property (@(posedge i_clk) disable iff (i_srst)
    !scaler_assign_sel |-> (ps_out == ps_r[scale_ratio_sel])) // [R05]
    else $error("timer ratio bit wrong");

  a_step_delay: assert property (@(posedge i_clk) disable iff (i_srst)
    s_pin_rise_bypass |-> s_step_soon) // [R07]
    else $error("step not within window");

  a_step_latency: assert property (@(posedge i_clk) disable iff (i_srst)
    (inc_r && lat_armed_r) |-> (int'(lat_r) + 3 >= LAT_MIN) &&
    (int'(lat_r) + 4 <= LAT_MAX)) // [R07]
    else $error("step latency out of range");

  a_dog_unscaled: assert property (@(posedge i_clk) disable iff (i_srst)
    (!scaler_assign_sel && !wr_option) |=>
    (o_dog_timeout == $past(i_dog_tick))) // [R08]
    else $error("dog scaled while timer owns scaler");

  a_option_take: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_option |=> (scaler_assign_sel ==
    $past(i_wdata[TPS_OPT_ASSIGN_BIT]))) // [R09] [R14]
    else $error("assignment write lost");

  a_clr_on_write: assert property (@(posedge i_clk) disable iff (i_srst)
    (!scaler_assign_sel && wr_count) |=> (ps_r == TPS_PS_RST)) // [R10]
    else $error("count write left scaler");

  a_clr_on_dog: assert property (@(posedge i_clk) disable iff (i_srst)
    (scaler_assign_sel && i_dog_clear_instr) |=>
    (ps_r == TPS_PS_RST)) // [R11]
    else $error("dog clear left scaler");

  a_unmapped_zero: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rd && i_addr != TPS_ADDR_COUNT && i_addr != TPS_ADDR_OPTION)
    |=> (o_rdata == '0)) // [R12]
    else $error("unmapped read not zero");

  a_reset_zero: assert property (@(posedge i_clk)
    i_srst |=> (ps_r == TPS_PS_RST) &&
    (o_count_register == TPS_COUNT_RST)) // [R13]
    else $error("reset did not zero");

  a_count_step: assert property (@(posedge i_clk) disable iff (i_srst)
    (inc_r && !wr_count) |=>
    (o_count_register == $past(o_count_register) + 1'b1)) // [R18]
    else $error("count did not step by one");

  a_count_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    (!inc_r && !wr_count) |=> $stable(o_count_register)) // [R18]
    else $error("count moved without cause");

  a_single_owner: assert property (@(posedge i_clk) disable iff (i_srst)
    (scaler_assign_sel && pin_rise && !i_dog_tick && !ps_clear)
    |=> $stable(ps_r)) // [R08]
    else $error("pin edge counted while dog owns scaler");

endmodule

`default_nettype wire

// File: verilog/tps_pkg.sv
// What this block does
// R01 - Oscillator divided by four into phases
// R02 - Unscaled timer sees count clock directly
// R03 - Scaler output sampled on phases two, four
// R04 - Source holds input two periods each level
// R05 - Timer prescaling by ripple divider, symmetric output
// R06 - Source period at least four periods per ratio
// R07 - Increment three to seven periods after edge
// R08 - One scaler, timer or watchdog, never both
// R09 - Low four option bits pick owner, ratio
// R10 - Count register writes clear timer scaler
// R11 - Watchdog clear also clears its scaler
// R12 - Scaler count never readable nor writable
// R13 - Reset loads scaler with zeros
// R14 - Assignment may change at any time
// R15 - Software clears dog, count, then reassigns
// R16 - Dog-to-timer switch uses dedicated sequence
// R17 - Assign bit one is watchdog; powers two
// R18 - Count steps once per synced rising edge
`default_nettype none

package tps_pkg;
  // Timing
  localparam int TPS_CLK_PERIOD_NS = 10;
  localparam int TPS_TOSC_NS = 10;
  localparam int TPS_NUM_PHASES = 4;
  localparam int TPS_INC_DLY_MIN_TOSC = 3;
  localparam int TPS_INC_DLY_MAX_TOSC = 7;
  localparam int TPS_INC_DLY_MIN_CYC =
    (TPS_INC_DLY_MIN_TOSC * TPS_TOSC_NS + TPS_CLK_PERIOD_NS - 1) /
    TPS_CLK_PERIOD_NS;
  localparam int TPS_INC_DLY_MAX_CYC =
    (TPS_INC_DLY_MAX_TOSC * TPS_TOSC_NS) / TPS_CLK_PERIOD_NS;
  localparam int TPS_EXT_MIN_HALF_TOSC = 2;
  localparam int TPS_EXT_MIN_HALF_CYC =
    (TPS_EXT_MIN_HALF_TOSC * TPS_TOSC_NS + TPS_CLK_PERIOD_NS - 1) /
    TPS_CLK_PERIOD_NS;

  // Widths
  localparam int TPS_PS_WIDTH = 8;
  localparam int TPS_CNT_WIDTH = 8;
  localparam int TPS_ADDR_WIDTH = 4;
  localparam int TPS_DATA_WIDTH = 8;

  // Register map
  localparam logic [3:0] TPS_ADDR_COUNT = 4'h1;
  localparam logic [3:0] TPS_ADDR_OPTION = 4'h2;

  // Option fields
  localparam int TPS_OPT_ASSIGN_BIT = 3;
  localparam int TPS_OPT_RATIO_LSB = 0;
  localparam int TPS_OPT_RATIO_W = 3;
  localparam int TPS_OPT_W = 4;

  // Reset values
  localparam logic [3:0] TPS_OPTION_RST = 4'hF;
  localparam logic [7:0] TPS_COUNT_RST = 8'h00;
  localparam logic [7:0] TPS_PS_RST = 8'h00;
  localparam logic [1:0] TPS_PHASE_RST = 2'h0;

  // Phase indices
  localparam logic [1:0] TPS_PH_ONE = 2'h0;
  localparam logic [1:0] TPS_PH_TWO = 2'h1;
  localparam logic [1:0] TPS_PH_THREE = 2'h2;
  localparam logic [1:0] TPS_PH_FOUR = 2'h3;

  typedef logic [TPS_OPT_RATIO_W-1:0] tps_ratio_t;
  typedef logic [TPS_PS_WIDTH-1:0] tps_byte_t;
endpackage

// Two-flop level synchroniser
module tps_sync2
  import tps_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule

`default_nettype wire

// File: testbench/tps_ext_src.sv
`default_nettype none

module tps_ext_src #(
  parameter int HALF = 3
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic [7:0] i_n,
  // Count pin and burst busy flag
  output logic o_pin,
  output logic o_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_r = 8'h00;
  int ph_r = 0;
  assign o_busy = (left_r != 8'h00);
  // Pin rests low between bursts, as a real source would
  assign o_pin = o_busy && (ph_r < HALF);
  always_ff @(posedge i_clk) begin
    if (i_start) begin
      left_r <= i_n;
      ph_r <= 0;
    end else if (o_busy) begin
      if (ph_r == 2 * HALF - 1) begin
        ph_r <= 0;
        left_r <= left_r - 8'h01;
      end else begin
        ph_r <= ph_r + 1;
      end
    end
  end
endmodule

`default_nettype wire

// File: testbench/testbench.sv
`default_nettype none

module testbench;
  import tps_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] CNT = TPS_ADDR_COUNT;
  localparam logic [3:0] OPT = TPS_ADDR_OPTION;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic tick = 1'b0;
  logic clr = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic go = 1'b0;
  logic [7:0] n = 8'h00;
  logic [7:0] rdata;
  logic [7:0] cnt;
  logic [7:0] c0;
  logic [3:0] ph;
  logic [3:0] p;
  logic [3:0] seen;
  logic to;
  logic pin;
  logic busy;
  int error_cnt = 0;
  int tests_run = 0;
  int to_n = 0;
  int k;

  always #5 clk = ~clk;

  always @(posedge clk)
    if (to === 1'b1)
      to_n <= to_n + 1;

  tps_timer dut (
    .i_clk(clk), .i_srst(srst), .i_ext_count_clock_in(pin),
    .i_dog_tick(tick), .i_dog_clear_instr(clr), .o_dog_timeout(to),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_phase(ph), .o_count_register(cnt)
  );

  tps_ext_src src (
    .i_clk(clk), .i_start(go), .i_n(n), .o_pin(pin), .o_busy(busy)
  );

  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  // Ends just after the edge at which the pin first rises
  task automatic kick(input logic [7:0] m);
    @(posedge clk);
    go <= 1'b1;
    n <= m;
    @(posedge clk);
    go <= 1'b0;
    #1;
  endtask

  task automatic run(input logic [7:0] m);
    kick(m);
    while (busy)
      @(posedge clk);
    // Let the synchroniser and increment drain
    repeat (10) @(posedge clk);
  endtask

  task automatic dog(input logic c);
    @(posedge clk);
    if (c)
      clr <= 1'b1;
    else
      tick <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tick <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    seen = ph;
    for (int i = 0; i < 4; i++) begin
      p = ph;
      @(posedge clk);
      #1;
      seen = seen | ph;
      chk({4'h0, ph}, {4'h0, p[2:0], p[3]});
    end
    chk({4'h0, seen}, 8'h0F);
    rdc(OPT, 8'h0F);
    rdc(CNT, 8'h00);
    rdc(4'h0, 8'h00);
    rdc(4'hF, 8'h00);
    wrr(OPT, 8'h00);
    run(8'd2);
    rdc(CNT, 8'h01);
    for (int r = 0; r < 3; r++) begin
      // Clear first so the new ratio bit starts low
      wrr(CNT, 8'h00);
      wrr(OPT, 8'(r));
      run(8'(3 << (r + 1)));
      rdc(CNT, 8'h03);
    end
    wrr(OPT, 8'h01);
    wrr(CNT, 8'h00);
    run(8'd1);
    wrr(CNT, 8'h10);
    run(8'd1);
    rdc(CNT, 8'h10);
    run(8'd1);
    rdc(CNT, 8'h11);
    dog(1'b1);
    wrr(CNT, 8'hFE);
    wrr(OPT, 8'h08);
    c0 = cnt;
    kick(8'd1);
    k = 0;
    while (cnt === c0 && k < 9) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(8'(k >= 3 && k <= 7), 8'h01);
    chk(cnt, 8'hFF);
    run(8'd1);
    rdc(CNT, 8'h00);
    wrr(OPT, 8'h09);
    dog(1'b1);
    dog(1'b0);
    dog(1'b1);
    dog(1'b0);
    chk(8'(to_n), 8'h00);
    dog(1'b0);
    chk(8'(to_n), 8'h01);
    dog(1'b1);
    wrr(OPT, 8'h01);
    dog(1'b0);
    chk(8'(to_n), 8'h02);
    tally_and_finish();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
